// ---- src/lmlc_pkg.sv ----
// Shared constants and types of the link monitor and loopback control block
package lmlc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned LMLC_CLK_KHZ      = 250000;
    localparam int unsigned LMLC_STAB_MS      = 330;
    // Least time, so the count is exact or rounded up
    localparam int unsigned LMLC_STAB_CYCLES  = LMLC_STAB_MS * LMLC_CLK_KHZ;
    localparam int unsigned LMLC_FIFO_DEPTH   = 4;

    // ************************************************************
    // Register indices
    // ************************************************************
    localparam logic [4:0]  LMLC_IDX_BCTRL    = 5'h00;
    localparam logic [4:0]  LMLC_IDX_BSTAT    = 5'h01;
    localparam logic [4:0]  LMLC_IDX_MODE     = 5'h11;
    localparam logic [4:0]  LMLC_IDX_AUX      = 5'h12;
    localparam logic [4:0]  LMLC_IDX_EVT      = 5'h1D;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          LMLC_BC_SRST      = 15;
    localparam int          LMLC_BC_LOOP      = 14;
    localparam int          LMLC_BC_SPEED     = 13;
    localparam int          LMLC_BC_ANEN      = 12;
    localparam int          LMLC_BC_COLT      = 7;
    localparam int          LMLC_BS_RFAULT    = 4;
    localparam int          LMLC_BS_LINK      = 2;
    localparam int          LMLC_MD_FAR       = 9;
    localparam int          LMLC_AUX_IDLE     = 0;
    localparam int          LMLC_AUX_RESTART  = 1;
    localparam int          LMLC_EV_DOWN      = 0;
    localparam int          LMLC_EV_UP        = 1;
    localparam int          LMLC_EV_SYMERR    = 2;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic        LMLC_LOOP_RST     = 1'b0;
    localparam logic        LMLC_SPEED_RST    = 1'b1;
    localparam logic        LMLC_ANEN_RST     = 1'b1;
    localparam logic        LMLC_COLT_RST     = 1'b0;
    localparam logic        LMLC_FAR_RST      = 1'b0;
    localparam logic        LMLC_IDLE_RST     = 1'b1;
    localparam logic [2:0]  LMLC_EVT_RST      = 3'h0;
    localparam logic [15:0] LMLC_ZERO16       = 16'h0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       err;
        logic [3:0] data;
    } lmlc_nib_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] idx;
        logic [15:0] wdata;
    } lmlc_mgmt_type;

    typedef enum logic [1:0] {
        LMLC_DOWN  = 2'b00,
        LMLC_STAB  = 2'b01,
        LMLC_READY = 2'b10,
        LMLC_UP    = 2'b11
    } lmlc_state_type;

endpackage

// ---- src/lmlc_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lmlc_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             clr_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rptr_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (clr_i) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // lmlc_fifo

// ---- src/lmlc_top.sv ----
// Link integrity monitor, loopback control and management bit semantics
// What this block does
// - Merged link status also drives link indicator
// - Valid line: ready, await negotiation, then link-up
// - Negotiation off: skip ready, go link-up
// - Wait at least 330 ms before ready
// - Valid loss: enter link-down immediately, dropping link outside 10 Mbps mode
// - 10 Mbps mode takes 10 Mbps receiver link
// - Loopback bit returns transmit data to receive
// - Loopback keeps collision quiet unless test set
// - Loopback powers line transmitters down
// - Far loopback returns partner data to partner
// - Far loopback isolates MAC side signals
// - Far loopback works only in RMII mode
// - Read-only bits ignore all writes
// - Write-only bits read back zero
// - Write one clears, write zero does nothing
// - Any write clears write-any-clear bits
// - Read-to-clear bits clear after read
// - Self-clearing bits return to zero alone
// - Self-setting bits return to one alone
// - Latch-high bit holds one until read
// - Soft-reset-immune bits survive software reset
// - Loopback control is control bit 14
// - Collision test control is control bit 7
`timescale 1ns/1ps
module lmlc_top
    import lmlc_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = LMLC_STAB_CYCLES,
    parameter int          FIFO_DEPTH  = LMLC_FIFO_DEPTH
) (
    input  wire logic          mclk_i,
    input  wire logic          nrst_i,
    input  wire lmlc_mgmt_type mgmt_i,
    output lmlc_nib_type       mgmt_pad_o,
    output logic [15:0]        mgmt_rdata_o,
    output logic               mgmt_rvalid_o,
    input  wire logic          rmii_mode_i,
    input  wire logic          data_valid_i,
    input  wire logic          link10_i,
    input  wire logic          remote_fault_i,
    input  wire logic          an_grant_i,
    input  wire logic          symbol_err_i,
    input  wire logic          mac_tx_en_i,
    input  wire lmlc_nib_type  mac_txd_i,
    output logic               mac_tx_ready_o,
    output logic               mac_rx_dv_o,
    output lmlc_nib_type       mac_rxd_o,
    output logic               mac_col_o,
    input  wire logic          line_rx_valid_i,
    input  wire lmlc_nib_type  line_rxd_i,
    input  wire logic          line_col_i,
    input  wire logic          line_tx_ready_i,
    output logic               line_tx_valid_o,
    output lmlc_nib_type       line_txd_o,
    output logic               line_tx_pwrdn_o,
    output logic               link_status_o,
    output logic               link_indicator_output_o,
    output logic               mac_isolated_o,
    output lmlc_state_type     link_state_o
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
        end else begin
            meta_reg <= {rmii_mode_i, remote_fault_i, link10_i, data_valid_i};
            sync_reg <= meta_reg;
        end
    end
    wire dv_s   = sync_reg[0];
    wire l10_s  = sync_reg[1];
    wire rf_s   = sync_reg[2];
    wire rmii_s = sync_reg[3];

    // ************************************************************
    // Management decode
    // ************************************************************
    wire wr_bc  = mgmt_i.wr & (mgmt_i.idx == LMLC_IDX_BCTRL);
    wire wr_md  = mgmt_i.wr & (mgmt_i.idx == LMLC_IDX_MODE);
    wire wr_aux = mgmt_i.wr & (mgmt_i.idx == LMLC_IDX_AUX);
    wire wr_ev  = mgmt_i.wr & (mgmt_i.idx == LMLC_IDX_EVT);
    wire rd_bs  = mgmt_i.rd & (mgmt_i.idx == LMLC_IDX_BSTAT);
    wire rd_ev  = mgmt_i.rd & (mgmt_i.idx == LMLC_IDX_EVT);

    // ************************************************************
    // Control register and software reset
    // ************************************************************
    logic srst_reg;
    logic loop_reg;
    logic speed_reg;
    logic anen_reg;
    logic colt_reg;
    // Soft reset takes one cycle, then clears itself
    wire  blk_rst = ~nrst_i | srst_reg;
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            srst_reg  <= 1'b0;
            loop_reg  <= LMLC_LOOP_RST;
            speed_reg <= LMLC_SPEED_RST;
            anen_reg  <= LMLC_ANEN_RST;
            colt_reg  <= LMLC_COLT_RST;
        end else if (wr_bc) begin
            srst_reg  <= mgmt_i.wdata[LMLC_BC_SRST];
            loop_reg  <= mgmt_i.wdata[LMLC_BC_LOOP];
            speed_reg <= mgmt_i.wdata[LMLC_BC_SPEED];
            anen_reg  <= mgmt_i.wdata[LMLC_BC_ANEN];
            colt_reg  <= mgmt_i.wdata[LMLC_BC_COLT];
        end
    end

    logic far_end_return_enable_reg;
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            far_end_return_enable_reg <= LMLC_FAR_RST;
        end else if (wr_md) begin
            far_end_return_enable_reg <= mgmt_i.wdata[LMLC_MD_FAR];
        end
    end

    // ************************************************************
    // Auxiliary bits: self-setting and write-only
    // ************************************************************
    logic idle_reg;
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            idle_reg <= LMLC_IDLE_RST;
        end else if (wr_aux && !mgmt_i.wdata[LMLC_AUX_IDLE]) begin
            idle_reg <= 1'b0;
        end else begin
            idle_reg <= 1'b1;
        end
    end

    wire restart_pulse = wr_aux & mgmt_i.wdata[LMLC_AUX_RESTART];

    // ************************************************************
    // Link monitor
    // ************************************************************
    lmlc_state_type state_reg;
    lmlc_state_type state_next;
    logic [31:0]    stab_cnt_reg;
    wire            stab_done = (stab_cnt_reg >= STAB_CYCLES - 32'd1);
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LMLC_DOWN: begin
                if (dv_s) begin
                    state_next = LMLC_STAB;
                end
            end
            LMLC_STAB: begin
                if (stab_done) begin
                    state_next = anen_reg ? LMLC_READY : LMLC_UP;
                end
            end
            LMLC_READY: begin
                if (an_grant_i) begin
                    state_next = LMLC_UP;
                end
            end
            LMLC_UP: begin
                state_next = LMLC_UP;
            end
            default: begin
                state_next = LMLC_DOWN;
            end
        endcase
        if (!dv_s || restart_pulse) begin
            state_next = LMLC_DOWN;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            state_reg <= LMLC_DOWN;
        end else begin
            state_reg <= state_next;
        end
    end
    // Counter only runs inside the wait state, so any drop discards it
    always_ff @(posedge mclk_i) begin
        if (blk_rst || state_reg != LMLC_STAB) begin
            stab_cnt_reg <= '0;
        end else if (!stab_done) begin
            stab_cnt_reg <= stab_cnt_reg + 32'h1;
        end
    end

    wire link_merged = speed_reg ? (state_reg == LMLC_UP) : l10_s;

    // ************************************************************
    // Status and event bits
    // ************************************************************
    logic       rfault_reg;
    logic [2:0] evt_reg;
    logic       link_q_reg;
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            rfault_reg <= 1'b0;
        end else if (rd_bs) begin
            rfault_reg <= rf_s;
        end else begin
            rfault_reg <= rfault_reg | rf_s;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            link_q_reg <= 1'b0;
        end else begin
            link_q_reg <= link_merged;
        end
    end

    wire up_evt   = link_merged & ~link_q_reg;
    wire down_evt = ~link_merged & link_q_reg;

    // A new event in the clearing cycle is kept
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            evt_reg <= LMLC_EVT_RST;
        end else begin
            evt_reg[LMLC_EV_DOWN] <= down_evt |
                (evt_reg[LMLC_EV_DOWN] & ~(wr_ev & mgmt_i.wdata[LMLC_EV_DOWN]));
            evt_reg[LMLC_EV_UP] <= up_evt | (evt_reg[LMLC_EV_UP] & ~wr_ev);
            evt_reg[LMLC_EV_SYMERR] <= symbol_err_i | (evt_reg[LMLC_EV_SYMERR] & ~rd_ev);
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = LMLC_ZERO16;
        case (mgmt_i.idx)
            LMLC_IDX_BCTRL: begin
                rd_mux[LMLC_BC_SRST]  = srst_reg;
                rd_mux[LMLC_BC_LOOP]  = loop_reg;
                rd_mux[LMLC_BC_SPEED] = speed_reg;
                rd_mux[LMLC_BC_ANEN]  = anen_reg;
                rd_mux[LMLC_BC_COLT]  = colt_reg;
            end
            LMLC_IDX_BSTAT: begin
                rd_mux[LMLC_BS_RFAULT] = rfault_reg;
                rd_mux[LMLC_BS_LINK]   = link_merged;
            end
            LMLC_IDX_MODE: begin
                rd_mux[LMLC_MD_FAR] = far_end_return_enable_reg;
            end
            LMLC_IDX_AUX: begin
                rd_mux[LMLC_AUX_IDLE] = idle_reg;
            end
            LMLC_IDX_EVT: begin
                rd_mux[2:0] = evt_reg;
            end
            default: begin
                rd_mux = LMLC_ZERO16;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            mgmt_rdata_o  <= LMLC_ZERO16;
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rvalid_o <= mgmt_i.rd;
            if (mgmt_i.rd) begin
                mgmt_rdata_o <= rd_mux;
            end
        end
    end

    // ************************************************************
    // Loopback data path
    // ************************************************************
    logic         fifo_in_ready;
    logic         fifo_out_valid;
    lmlc_nib_type fifo_out_data;
    wire          near_lb = loop_reg;
    // Far loopback is ignored outside RMII, trading test reach for safety
    wire          far_lb  = far_end_return_enable_reg & rmii_s & ~loop_reg;
    wire          fifo_out_ready = near_lb ? 1'b1 : (far_lb ? 1'b0 : line_tx_ready_i);
    assign mac_tx_ready_o = fifo_in_ready & ~far_lb;

    lmlc_fifo #(
        .WIDTH ($bits(lmlc_nib_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .mclk_i      (mclk_i),
        .clr_i       (blk_rst),
        .in_valid_i  (mac_tx_en_i & ~far_lb),
        .in_data_i   (mac_txd_i),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_out_ready)
    );
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            line_tx_valid_o <= 1'b0;
            line_txd_o      <= '0;
        end else if (far_lb) begin
            line_tx_valid_o <= line_rx_valid_i;
            line_txd_o      <= line_rxd_i;
        end else if (near_lb) begin
            line_tx_valid_o <= 1'b0;
            line_txd_o      <= '0;
        end else begin
            line_tx_valid_o <= fifo_out_valid & line_tx_ready_i;
            line_txd_o      <= fifo_out_data;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            mac_rx_dv_o <= 1'b0;
            mac_rxd_o   <= '0;
        end else if (far_lb) begin
            mac_rx_dv_o <= 1'b0;
            mac_rxd_o   <= '0;
        end else if (near_lb) begin
            mac_rx_dv_o <= fifo_out_valid;
            mac_rxd_o   <= fifo_out_data;
        end else begin
            mac_rx_dv_o <= line_rx_valid_i;
            mac_rxd_o   <= line_rxd_i;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            mac_col_o <= 1'b0;
        end else if (far_lb) begin
            mac_col_o <= 1'b0;
        end else if (colt_reg) begin
            mac_col_o <= mac_tx_en_i;
        end else begin
            mac_col_o <= near_lb ? 1'b0 : line_col_i;
        end
    end

    // ************************************************************
    // Status outputs
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            line_tx_pwrdn_o         <= 1'b0;
            link_status_o           <= 1'b0;
            link_indicator_output_o <= 1'b0;
            mac_isolated_o          <= 1'b0;
        end else begin
            line_tx_pwrdn_o         <= near_lb;
            link_status_o           <= link_merged;
            link_indicator_output_o <= link_merged;
            mac_isolated_o          <= far_lb;
        end
    end
    assign link_state_o = state_reg;
    assign mgmt_pad_o   = '0;

endmodule // lmlc_top

// ---- bench/lmlc_chk.sv ----
// Port checker for the link monitor and loopback control block
`timescale 1ns/1ps
module lmlc_chk
    import lmlc_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = 20
) (
    input wire logic           mclk_i,
    input wire logic           nrst_i,
    input wire logic           data_valid_i,
    input wire logic           an_grant_i,
    input wire logic           mac_rx_dv_o,
    input wire logic           mac_col_o,
    input wire logic           mac_tx_ready_o,
    input wire logic           line_rx_valid_i,
    input wire lmlc_nib_type   line_rxd_i,
    input wire logic           line_tx_valid_o,
    input wire lmlc_nib_type   line_txd_o,
    input wire logic           line_tx_pwrdn_o,
    input wire logic           link_status_o,
    input wire logic           link_indicator_output_o,
    input wire logic           mac_isolated_o,
    input wire lmlc_state_type link_state_o
);
    logic [31:0] stab_cnt_reg;
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || link_state_o != LMLC_STAB)
            stab_cnt_reg <= 32'h0;
        else
            stab_cnt_reg <= stab_cnt_reg + 32'h1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    a_led_match: assert property (link_indicator_output_o == link_status_o)
        else $error("indicator differs from status");
    // Two cycles cover the input synchroniser, one the state register, plus one spare cycle
    a_down_loss: assert property (!data_valid_i [*4] |=> link_state_o == LMLC_DOWN)
        else $error("link not down after valid loss");
    a_ready_entry: assert property (link_state_o == LMLC_READY && $past(link_state_o) != LMLC_READY
        |-> $past(link_state_o) == LMLC_STAB) else $error("ready without stabilising");
    a_up_grant: assert property (link_state_o == LMLC_UP && $past(link_state_o) == LMLC_READY
        |-> $past(an_grant_i)) else $error("link up without negotiation grant");
    a_stab_time: assert property ($past(link_state_o) == LMLC_STAB
        && link_state_o inside {LMLC_READY, LMLC_UP} |-> stab_cnt_reg >= STAB_CYCLES)
        else $error("stabilisation wait too short");
    a_near_quiet: assert property (line_tx_pwrdn_o && $past(line_tx_pwrdn_o) |-> !line_tx_valid_o)
        else $error("transmit in near loopback");
    a_far_iso: assert property (mac_isolated_o && $past(mac_isolated_o)
        |-> !mac_rx_dv_o && !mac_col_o && !mac_tx_ready_o) else $error("mac side not isolated");
    a_far_echo: assert property (mac_isolated_o && $past(mac_isolated_o)
        |-> line_tx_valid_o == $past(line_rx_valid_i) && line_txd_o == $past(line_rxd_i))
        else $error("far data not echoed");
endmodule // lmlc_chk

// ---- bench/lmlc_line_model.sv ----
// Line-side link partner: sends nibbles and collects transmitted ones
`timescale 1ns/1ps
module lmlc_line_model
    import lmlc_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         stall_i,
    input  wire logic         tx_valid_i,
    input  wire lmlc_nib_type txd_i,
    output logic              tx_ready_o,
    output logic              rx_valid_o,
    output lmlc_nib_type      rxd_o,
    output logic              col_o
);
    lmlc_nib_type got[$];
    lmlc_nib_type data_reg = 5'h00;
    lmlc_nib_type idle_reg = 5'h00;
    initial rx_valid_o = 1'h0;
    assign tx_ready_o = !stall_i;
    assign col_o      = 1'h0;
    // Idle data flips every cycle so a stale nibble never looks valid
    assign rxd_o      = rx_valid_o ? data_reg : idle_reg;
    always @(posedge mclk_i) begin
        idle_reg <= ~idle_reg;
        if (tx_valid_i === 1'h1)
            got.push_back(txd_i);
    end
    task send(input lmlc_nib_type d);
        @(posedge mclk_i);
        rx_valid_o <= 1'h1;
        data_reg   <= d;
        @(posedge mclk_i);
        rx_valid_o <= 1'h0;
    endtask
endmodule // lmlc_line_model

// ---- bench/testbench.sv ----
// Self-checking bench for the link monitor and loopback control block
`timescale 1ns/1ps
module testbench;
    import lmlc_pkg::*;
    localparam int unsigned STAB = 20;
    logic mclk_i = 1'h0, nrst_i = 1'h0, rmii_mode_i = 1'h0, data_valid_i = 1'h0, link10_i = 1'h0;
    logic remote_fault_i = 1'h0, an_grant_i = 1'h0, symbol_err_i = 1'h0, mac_tx_en_i = 1'h0, stall = 1'h0;
    lmlc_mgmt_type mgmt_i = '0;
    lmlc_nib_type  mac_txd_i = 5'h00;
    logic line_rx_valid_i, line_col_i, line_tx_ready_i, mgmt_rvalid_o, mac_tx_ready_o, mac_rx_dv_o;
    logic mac_col_o, line_tx_valid_o, line_tx_pwrdn_o, link_status_o, link_indicator_output_o, mac_isolated_o;
    logic [15:0]    mgmt_rdata_o;
    lmlc_nib_type   line_rxd_i, mac_rxd_o, line_txd_o, rxq[$];
    lmlc_state_type link_state_o;
    int   n_fail = 0, n_tests = 0, n_col = 0;
    logic saw_rdy = 1'h0;
    lmlc_top #(.STAB_CYCLES(STAB)) lmlc_top_i (.*, .mgmt_pad_o());
    lmlc_line_model lmlc_line_model_i (.mclk_i, .stall_i(stall), .tx_valid_i(line_tx_valid_o),
        .txd_i(line_txd_o), .tx_ready_o(line_tx_ready_i), .rx_valid_o(line_rx_valid_i),
        .rxd_o(line_rxd_i), .col_o(line_col_i));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (mac_rx_dv_o === 1'h1) rxq.push_back(mac_rxd_o);
        if (mac_col_o === 1'h1) n_col++;
        if (link_state_o === LMLC_READY) saw_rdy = 1'h1;
    end
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task wr(input logic [4:0] idx, input logic [15:0] d);
        @(posedge mclk_i);
        mgmt_i <= '{1'h1, 1'h0, idx, d};
        @(posedge mclk_i);
        mgmt_i <= '0;
    endtask
    task rdc(input string nm, input logic [4:0] idx, input logic [15:0] msk, input logic [15:0] exp);
        @(posedge mclk_i);
        mgmt_i <= '{1'h0, 1'h1, idx, 16'h0000};
        @(posedge mclk_i);
        mgmt_i <= '0;
        #1;
        chk("rvalid", {15'h0, mgmt_rvalid_o}, 16'h0001);
        chk(nm, mgmt_rdata_o & msk, exp);
    endtask
    // Bounded waits reach the verdict
    task waitst(input lmlc_state_type s, output int n);
        n = 0;
        while (link_state_o !== s && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 200) begin
            n_fail++;
            test_done;
        end
    endtask
    task tx(input lmlc_nib_type d);
        int i;
        @(posedge mclk_i);
        mac_tx_en_i <= 1'h1;
        mac_txd_i   <= d;
        i = 0;
        do begin
            @(posedge mclk_i);
            i++;
        end while (mac_tx_ready_o !== 1'h1 && i < 50);
        mac_tx_en_i <= 1'h0;
        if (i >= 50) begin
            n_fail++;
            test_done;
        end
    endtask
    initial begin
        int n;
        cyc(10);
        nrst_i <= 1'h1;
        rdc("ctrl", LMLC_IDX_BCTRL, 16'hFFFF, 16'h3000);
        wr(LMLC_IDX_BSTAT, 16'hFFFF);
        rdc("stat", LMLC_IDX_BSTAT, 16'h0014, 16'h0000);
        wr(LMLC_IDX_AUX, 16'h0000);
        cyc(3);
        rdc("sset", LMLC_IDX_AUX, 16'h0001, 16'h0001);
        remote_fault_i <= 1'h1;
        cyc(4);
        remote_fault_i <= 1'h0;
        cyc(4);
        rdc("flt", LMLC_IDX_BSTAT, 16'h0010, 16'h0010);
        rdc("flt", LMLC_IDX_BSTAT, 16'h0010, 16'h0000);
        data_valid_i <= 1'h1;
        cyc(10);
        data_valid_i <= 1'h0;
        cyc(5);
        data_valid_i <= 1'h1;
        waitst(LMLC_READY, n);
        chk("stab", {15'h0, n >= STAB}, 16'h0001);
        chk("link", {15'h0, link_status_o}, 16'h0000);
        an_grant_i <= 1'h1;
        waitst(LMLC_UP, n);
        cyc(2);
        chk("link", {15'h0, link_status_o}, 16'h0001);
        chk("led", {15'h0, link_indicator_output_o}, 16'h0001);
        data_valid_i <= 1'h0;
        cyc(5);
        chk("state", {14'h0, link_state_o}, 16'h0000);
        chk("link", {15'h0, link_status_o}, 16'h0000);
        rdc("evt", LMLC_IDX_EVT, 16'h0003, 16'h0003);
        wr(LMLC_IDX_EVT, 16'h0000);
        rdc("evt", LMLC_IDX_EVT, 16'h0003, 16'h0001);
        wr(LMLC_IDX_EVT, 16'h0001);
        rdc("evt", LMLC_IDX_EVT, 16'h0003, 16'h0000);
        symbol_err_i <= 1'h1;
        cyc(1);
        symbol_err_i <= 1'h0;
        wr(LMLC_IDX_EVT, 16'h0000);
        rdc("serr", LMLC_IDX_EVT, 16'h0004, 16'h0004);
        rdc("serr", LMLC_IDX_EVT, 16'h0004, 16'h0000);
        wr(LMLC_IDX_BCTRL, 16'h2000);
        saw_rdy = 1'h0;
        data_valid_i <= 1'h1;
        waitst(LMLC_UP, n);
        chk("ready", {15'h0, saw_rdy}, 16'h0000);
        data_valid_i <= 1'h0;
        wr(LMLC_IDX_BCTRL, 16'h0000);
        link10_i <= 1'h1;
        cyc(6);
        chk("link10", {15'h0, link_status_o}, 16'h0001);
        link10_i <= 1'h0;
        cyc(6);
        chk("link10", {15'h0, link_status_o}, 16'h0000);
        wr(LMLC_IDX_BCTRL, 16'h3000);
        stall <= 1'h1;
        for (int i = 0; i < 4; i++) tx(5'(i));
        cyc(2);
        chk("full", {15'h0, mac_tx_ready_o}, 16'h0000);
        stall <= 1'h0;
        tx(5'h04);
        cyc(8);
        chk("txn", 16'(lmlc_line_model_i.got.size()), 16'h0005);
        for (int i = 0; i < 5; i++) chk("txd", {11'h0, lmlc_line_model_i.got[i]}, 16'(i));
        wr(LMLC_IDX_BCTRL, 16'h7000);
        wr(LMLC_IDX_MODE, 16'h0200);
        n_col = 0;
        for (int i = 0; i < 3; i++) tx(5'(9 + i));
        cyc(6);
        chk("pwrdn", {15'h0, line_tx_pwrdn_o}, 16'h0001);
        chk("col", 16'(n_col), 16'h0000);
        chk("rxn", 16'(rxq.size()), 16'h0003);
        for (int i = 0; i < 3; i++) chk("rxd", {11'h0, rxq[i]}, 16'(9 + i));
        wr(LMLC_IDX_BCTRL, 16'h7080);
        tx(5'h01);
        cyc(3);
        chk("colt", {15'h0, n_col > 0}, 16'h0001);
        wr(LMLC_IDX_BCTRL, 16'h8000);
        cyc(3);
        rdc("srst", LMLC_IDX_BCTRL, 16'hFFFF, 16'h3000);
        rdc("far", LMLC_IDX_MODE, 16'h0200, 16'h0200);
        chk("iso", {15'h0, mac_isolated_o}, 16'h0000);
        rmii_mode_i <= 1'h1;
        cyc(5);
        chk("iso", {15'h0, mac_isolated_o}, 16'h0001);
        lmlc_line_model_i.got.delete();
        for (int i = 0; i < 3; i++) lmlc_line_model_i.send(5'(5 + i));
        cyc(4);
        chk("echo", 16'(lmlc_line_model_i.got.size()), 16'h0003);
        for (int i = 0; i < 3; i++) chk("echo", {11'h0, lmlc_line_model_i.got[i]}, 16'(5 + i));
        test_done;
    end
endmodule // testbench
bind lmlc_top lmlc_chk #(.STAB_CYCLES(STAB_CYCLES)) lmlc_chk_i (.*);
